/* File: common/split_match_pkg.sv */
/*
 Constants, types and the identifier compare for the
 complete-split response matcher.
 Assumes one 50 MHz clock shared with the microframe timer.
*/
package split_match_pkg;

    localparam int CLK_PERIOD_NS = 20;
    // Store sizing per microframe and pipeline stage
    localparam int ENTRIES_PER_UFRAME = 16;
    localparam int CS_STAGE_UFRAMES = 2;
    localparam int SS_STAGE_UFRAMES = 4;
    localparam int CS_STAGE_BYTES = 188;
    localparam int SS_STAGE_BYTES = 752;
    localparam int STATUS_BYTES_MAX = 4;
    localparam int NP_BUFFERS = 2;
    localparam int NP_DATA_BYTES = 64;
    localparam int NP_STATUS_BYTES = 4;
    // Answer window before the first request is left to time out
    localparam int SEARCH_BUDGET_NS = 200;
    localparam int SEARCH_BUDGET_CYC =
        (SEARCH_BUDGET_NS / CLK_PERIOD_NS < 1) ? 1 :
        SEARCH_BUDGET_NS / CLK_PERIOD_NS;
    localparam int RSP_FIFO_DEPTH = 2;
    localparam logic [1:0] FIFO_CNT_RESET = 2'h0;
    localparam logic BANK_RESET = 1'h0;

    typedef enum logic [1:0] {
        OUT_DATA = 2'h0,
        OUT_NAK = 2'h1,
        OUT_STALL = 2'h2,
        OUT_ERR = 2'h3
    } outcome_t;

    typedef enum logic [2:0] {
        ANS_DATA = 3'h0,
        ANS_NAK = 3'h1,
        ANS_STALL = 3'h2,
        ANS_ERR = 3'h3,
        ANS_NYET = 3'h4
    } answer_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'h1,
        S_SCAN = 2'h2
    } fsm_t;

    // 22 bits of status, under four bytes
    typedef struct packed {
        logic [6:0] addr;
        logic [3:0] endp;
        logic dirIn;
        outcome_t outcome;
        logic [7:0] len;
    } entry_t;

    function automatic logic idMatch(input entry_t e,
        input logic [6:0] a, input logic [3:0] ep, input logic d);
        idMatch = (e.addr == a) && (e.endp == ep) && (e.dirIn == d);
    endfunction : idMatch

endpackage : split_match_pkg

/* File: src/split_complete_response_matcher.sv */
/*
 Complete-split response matcher of a speed_translator.
 Holds two microframe banks of full/low-speed outcomes and
 answers complete-split requests from the previous bank.
 Assumes the microframe timer and the full/low-speed engine
 run on clk; entry payload bytes live in a store addressed
 by the answered bank and index.
*/
// Operation
// R1 - Host keeps complete-splits in start-split order
// R2 - Search queue, answer with finished outcome
// R3 - Search only previous microframe's entries
// R4 - First request may time out, retry answered
// R5 - Head match returns head entry
// R6 - Retried head request answered again identically
// R7 - Later match releases earlier entries, advances head
// R8 - No entry found answers NYET
// R9 - Host counts last-slot NYET as error
// R10 - Host halts endpoint after three errors (host model sets halted only once strikes exceed three)
// R11 - Payload per bank within byte limit
// R12 - Sixteen sub-four-byte status entries per microframe
// R13 - Complete-split stage holds two microframes
// R14 - At most sixteen transactions per microframe
// R15 - Non-periodic buffers: two of 64+4 bytes
// R16 - No local retry for interrupt errors
// R17 - Free entries from two microframes back
// R18 - Store data, NAK, STALL or error outcome
// R19 - Match address, endpoint and direction
`timescale 1ns/100ps
module split_complete_response_matcher
    import split_match_pkg::*;
#(
    parameter int ENTRIES = ENTRIES_PER_UFRAME,
    parameter int BANK_BYTES = CS_STAGE_BYTES,
    parameter int SEARCH_CYC = SEARCH_BUDGET_CYC
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic microframeStart,
    input wire logic entWrValid,
    output logic entWrReady,
    input wire logic [6:0] entAddr,
    input wire logic [3:0] entEndp,
    input wire logic entDirIn,
    input wire logic [1:0] entOutcome,
    input wire logic [7:0] entLen,
    input wire logic fsDone,
    input wire logic fsErr,
    input wire logic fsIsInterrupt,
    output logic fsRetryReq,
    input wire logic csValid,
    output logic csReady,
    input wire logic [6:0] csAddr,
    input wire logic [3:0] csEndp,
    input wire logic csDirIn,
    output logic rspValid,
    input wire logic rspReady,
    output logic [2:0] rspKind,
    output logic [7:0] rspLen,
    output logic rspBank,
    output logic [3:0] rspIdx
);

    localparam int IW = $clog2(ENTRIES);
    localparam int CW = $clog2(ENTRIES + 1);
    localparam int BW = $clog2(BANK_BYTES + 1);
    // Non-periodic space sits outside this periodic bank store
    localparam int NP_SPACE = NP_BUFFERS *
        (NP_DATA_BYTES + NP_STATUS_BYTES); // R15

    typedef struct packed {
        answer_t kind;
        logic [7:0] len;
        logic bank;
        logic [3:0] idx;
    } rsp_t;

    typedef struct packed {
        logic bankCur;
        logic [1:0][CW-1:0] cnt;
        logic [1:0][BW-1:0] bytes;
        logic [CW-1:0] head;
        entry_t [1:0][ENTRIES-1:0] ent;
        fsm_t fsm;
        logic [CW-1:0] scanIdx;
        logic [7:0] budget;
        logic timedOut;
        logic [6:0] reqAddr;
        logic [3:0] reqEndp;
        logic reqDir;
        logic cacheValid;
        logic [IW-1:0] cacheIdx;
        rsp_t [RSP_FIFO_DEPTH-1:0] fifo;
        logic fifoRd;
        logic [1:0] fifoCnt;
        logic retry;
    } st_t;

    st_t stReg;
    st_t stNext;
    logic pushEn;
    rsp_t pushVal;
    logic popEn;
    logic prevBank;
    logic wrBank;
    logic scanHit;
    entry_t wrEnt;
    entry_t scanEnt;
    entry_t cacheEnt;

    ////////////////////////////////////////////////////////////

    function automatic rsp_t mkRsp(input entry_t e,
        input logic b, input logic [3:0] i);
        mkRsp.kind = answer_t'({1'b0, e.outcome});
        mkRsp.len = e.len;
        mkRsp.bank = b;
        mkRsp.idx = i;
    endfunction : mkRsp

    ////////////////////////////////////////////////////////////

    always_comb
    begin
        stNext = stReg;
        pushEn = 1'b0;
        pushVal = '0;
        prevBank = ~stReg.bankCur;
        scanEnt = stReg.ent[prevBank][stReg.scanIdx[IW-1:0]];
        cacheEnt = stReg.ent[prevBank][stReg.cacheIdx];
        scanHit = idMatch(scanEnt, stReg.reqAddr, stReg.reqEndp,
            stReg.reqDir); // R19
        popEn = (stReg.fifoCnt != 2'h0) && rspReady;
        // Interrupts never retry on the downstream bus
        stNext.retry = fsDone && fsErr && !fsIsInterrupt; // R16

        // Bank swap: the NOW-2 bank is freed for reuse
        if (microframeStart)
        begin
            stNext.bankCur = ~stReg.bankCur; // R13
            stNext.cnt[prevBank] = '0; // R17
            stNext.bytes[prevBank] = '0; // R17
            stNext.head = '0;
            stNext.cacheValid = 1'b0;
            // A search cut by the swap simply times out
            stNext.fsm = S_IDLE;
        end
        wrBank = stNext.bankCur;

        // Capture of downstream outcomes
        entWrReady = (int'(stNext.cnt[wrBank]) < ENTRIES) &&
            (int'(stNext.bytes[wrBank]) + int'(entLen)
            <= BANK_BYTES); // R11 R14
        wrEnt.addr = entAddr;
        wrEnt.endp = entEndp;
        wrEnt.dirIn = entDirIn;
        wrEnt.outcome = outcome_t'(entOutcome); // R18
        wrEnt.len = entLen;
        if (entWrValid && entWrReady)
        begin
            stNext.ent[wrBank][stNext.cnt[wrBank][IW-1:0]] =
                wrEnt; // R12 R18
            stNext.cnt[wrBank] = CW'(stNext.cnt[wrBank] + 1'b1);
            stNext.bytes[wrBank] =
                BW'(stNext.bytes[wrBank] + entLen); // R11
        end

        // Request side: one request in flight at a time
        csReady = (stReg.fsm == S_IDLE) && !microframeStart &&
            (stReg.fifoCnt != 2'(RSP_FIFO_DEPTH));
        case (stReg.fsm)
            S_IDLE:
            begin
                if (csValid && csReady)
                begin
                    if (stReg.cacheValid && idMatch(cacheEnt,
                        csAddr, csEndp, csDirIn))
                    begin
                        // Retry of the last matched request, timed out or answered
                        pushEn = 1'b1; // R4
                        pushVal = mkRsp(cacheEnt, prevBank,
                            4'(stReg.cacheIdx));
                    end
                    else
                    begin
                        stNext.fsm = S_SCAN;
                        stNext.scanIdx = stReg.head; // R2
                        stNext.budget = 8'h00;
                        stNext.timedOut = 1'b0;
                        stNext.reqAddr = csAddr;
                        stNext.reqEndp = csEndp;
                        stNext.reqDir = csDirIn;
                    end
                end
            end
            S_SCAN:
            begin
                if (!microframeStart)
                begin
                    stNext.budget = 8'(stReg.budget + 1'b1);
                    if (int'(stReg.budget) >= SEARCH_CYC - 1)
                    begin
                        stNext.timedOut = 1'b1; // R4
                    end
                    // Only the previous microframe is searched
                    if (stReg.scanIdx >= stReg.cnt[prevBank])
                    begin
                        stNext.fsm = S_IDLE;
                        pushEn = !stReg.timedOut; // R4
                        pushVal.kind = ANS_NYET; // R8
                        pushVal.len = 8'h00;
                        pushVal.bank = prevBank;
                        pushVal.idx = 4'h0;
                    end
                    else if (scanHit)
                    begin
                        stNext.fsm = S_IDLE;
                        // Entries ahead of the match are dropped
                        stNext.head = stReg.scanIdx; // R5 R7
                        stNext.cacheValid = 1'b1; // R6
                        stNext.cacheIdx = stReg.scanIdx[IW-1:0];
                        pushEn = !stReg.timedOut; // R4
                        pushVal = mkRsp(scanEnt, prevBank,
                            4'(stReg.scanIdx)); // R2
                    end
                    else
                    begin
                        stNext.scanIdx =
                            CW'(stReg.scanIdx + 1'b1); // R3
                    end
                end
            end
            default:
            begin
                stNext.fsm = S_IDLE;
            end
        endcase

        // Two-entry answer buffer: a stalled receiver loses none
        if (popEn)
        begin
            stNext.fifoRd = ~stReg.fifoRd;
        end
        if (pushEn)
        begin
            stNext.fifo[stReg.fifoRd ^ stReg.fifoCnt[0]] = pushVal;
        end
        stNext.fifoCnt = 2'(stReg.fifoCnt + {1'b0, pushEn}
            - {1'b0, popEn});
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            stReg <= '0;
            stReg.fsm <= S_IDLE;
            stReg.bankCur <= BANK_RESET;
            stReg.fifoCnt <= FIFO_CNT_RESET;
        end
        else
        begin
            stReg <= stNext;
        end
    end

    assign rspValid = (stReg.fifoCnt != 2'h0);
    assign rspKind = stReg.fifo[stReg.fifoRd].kind;
    assign rspLen = stReg.fifo[stReg.fifoRd].len;
    assign rspBank = stReg.fifo[stReg.fifoRd].bank;
    assign rspIdx = stReg.fifo[stReg.fifoRd].idx;
    assign fsRetryReq = stReg.retry;

    ////////////////////////////////////////////////////////////
    // Checks

    chk_bank_depth: assert property ( // R14
        @(posedge clk) disable iff (!reset_n)
        int'(stReg.cnt[0]) <= ENTRIES &&
        int'(stReg.cnt[1]) <= ENTRIES)
        else $error("bank holds too many entries");

    chk_bank_bytes: assert property ( // R11
        @(posedge clk) disable iff (!reset_n)
        int'(stReg.bytes[stReg.bankCur]) <= BANK_BYTES)
        else $error("bank payload over limit");

    chk_old_freed: assert property ( // R17
        @(posedge clk) disable iff (!reset_n)
        microframeStart |=> stReg.cnt[stReg.bankCur] <= 1 &&
        stReg.head == '0)
        else $error("stale bank not freed");

    chk_head_range: assert property ( // R7
        @(posedge clk) disable iff (!reset_n)
        stReg.fsm == S_SCAN && scanHit && !microframeStart &&
        stReg.scanIdx < stReg.cnt[prevBank]
        |=> stReg.head == $past(stReg.scanIdx))
        else $error("head not moved to match");

    chk_no_int_retry: assert property ( // R16
        @(posedge clk) disable iff (!reset_n)
        fsRetryReq |-> $past(fsDone && fsErr && !fsIsInterrupt))
        else $error("local retry for interrupt");

    chk_scan_bound: assert property ( // R2
        @(posedge clk) disable iff (!reset_n)
        $rose(stReg.fsm == S_SCAN)
        |-> ##[1:17] stReg.fsm == S_IDLE)
        else $error("search did not finish");

    chk_nyet_miss: assert property ( // R8
        @(posedge clk) disable iff (!reset_n)
        stReg.fsm == S_SCAN && !microframeStart &&
        !stReg.timedOut && stReg.scanIdx >= stReg.cnt[prevBank]
        |=> rspValid && stReg.fifo[$past(stReg.fifoRd ^
        stReg.fifoCnt[0])].kind == ANS_NYET)
        else $error("miss not answered with NYET");

    chk_match_ids: assert property ( // R19
        @(posedge clk) disable iff (!reset_n)
        pushEn && pushVal.kind != ANS_NYET |->
        stReg.ent[pushVal.bank][pushVal.idx[IW-1:0]].len ==
        pushVal.len &&
        stReg.ent[pushVal.bank][pushVal.idx[IW-1:0]].addr ==
        (stReg.fsm == S_SCAN ? stReg.reqAddr : csAddr) &&
        stReg.ent[pushVal.bank][pushVal.idx[IW-1:0]].endp ==
        (stReg.fsm == S_SCAN ? stReg.reqEndp : csEndp))
        else $error("answer not from matched entry");

    chk_ready_gate: assert property ( // R4
        @(posedge clk) disable iff (!reset_n)
        stReg.fsm == S_SCAN |-> !csReady)
        else $error("request taken during search");

endmodule : split_complete_response_matcher

/* File: dv/split_host_model.sv */
/*
 Host side of the complete-split interface: issues requests,
 retries when no answer comes, keeps the strike count.
 Assumes the bench calls split and pop at falling edges.
*/
`timescale 1ns/100ps
module split_host_model
    import split_match_pkg::*;
(
    input wire logic clk,
    input wire logic csReady,
    output logic csValid,
    output logic [6:0] csAddr,
    output logic [3:0] csEndp,
    output logic csDirIn,
    input wire logic rspValid,
    output logic rspReady,
    input wire logic [2:0] rspKind,
    input wire logic [7:0] rspLen,
    input wire logic rspBank,
    input wire logic [3:0] rspIdx
);
    int strikes = 0;
    logic halted = 1'h0;
    initial
    begin
        csValid = 1'h0;
        csAddr = 7'h0;
        csEndp = 4'h0;
        csDirIn = 1'h0;
        rspReady = 1'h0;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic pop(output logic [2:0] k, output logic [7:0] n,
        output logic [4:0] s);
        k = rspKind;
        n = rspLen;
        s = {rspBank, rspIdx};
        rspReady = 1'h1;
        @(negedge clk);
        rspReady = 1'h0;
    endtask : pop
    // Hold leaves answers unread so the answer buffer fills up
    task automatic split(input logic [6:0] a, input logic [3:0] ep,
        input logic d, input logic last, input logic hold,
        output logic [2:0] k, output logic [7:0] n,
        output logic [4:0] s, output int tries);
        int w;
        k = 3'h7;
        n = 8'h0;
        s = 5'h0;
        tries = 0;
        while (k === 3'h7 && tries < 3)
        begin
            tries++;
            csValid = 1'h1;
            csAddr = a;
            csEndp = ep;
            csDirIn = d;
            w = 0;
            #1;
            while (csReady !== 1'h1 && w < 40)
            begin
                @(negedge clk);
                #1;
                w++;
            end
            @(negedge clk);
            // Released lines show the inverse, not a stale request
            csValid = 1'h0;
            csAddr = ~a;
            csEndp = ~ep;
            csDirIn = ~d;
            w = 0;
            while (!hold && rspValid !== 1'h1 && w < 16)
            begin
                @(negedge clk);
                w++;
            end
            if (hold)
            begin
                repeat (4) @(negedge clk);
                tries = 3;
            end
            else if (rspValid === 1'h1)
                pop(k, n, s);
        end
        if (last && k === ANS_NYET)
            strikes++;
        halted = strikes > 3;
    endtask : split
endmodule : split_host_model

/* File: dv/split_complete_response_matcher_tb_top.sv */
/*
 Self-checking bench for the complete-split response matcher.
 Assumes split_host_model drives the complete-split side.
*/
`timescale 1ns/100ps
module split_complete_response_matcher_tb_top;
    import split_match_pkg::*;
    logic clk, reset_n, microframeStart, entWrValid, entWrReady;
    logic [6:0] entAddr, csAddr;
    logic [3:0] entEndp, csEndp, rspIdx;
    logic [1:0] entOutcome;
    logic [7:0] entLen, rspLen;
    logic [2:0] rspKind;
    logic entDirIn, fsDone, fsErr, fsIsInterrupt, fsRetryReq;
    logic csValid, csReady, csDirIn, rspValid, rspReady, rspBank;
    int failCount = 0;
    int numChecks = 0;
    // Short budget so a deep search times out
    split_complete_response_matcher #(.SEARCH_CYC(8)) i_dut (
        .clk(clk), .reset_n(reset_n), .microframeStart(microframeStart),
        .entWrValid(entWrValid), .entWrReady(entWrReady),
        .entAddr(entAddr), .entEndp(entEndp), .entDirIn(entDirIn),
        .entOutcome(entOutcome), .entLen(entLen), .fsDone(fsDone),
        .fsErr(fsErr), .fsIsInterrupt(fsIsInterrupt),
        .fsRetryReq(fsRetryReq), .csValid(csValid), .csReady(csReady),
        .csAddr(csAddr), .csEndp(csEndp), .csDirIn(csDirIn),
        .rspValid(rspValid), .rspReady(rspReady), .rspKind(rspKind),
        .rspLen(rspLen), .rspBank(rspBank), .rspIdx(rspIdx));
    split_host_model i_host (
        .clk(clk), .csReady(csReady), .csValid(csValid),
        .csAddr(csAddr), .csEndp(csEndp), .csDirIn(csDirIn),
        .rspValid(rspValid), .rspReady(rspReady), .rspKind(rspKind),
        .rspLen(rspLen), .rspBank(rspBank), .rspIdx(rspIdx));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        numChecks++;
        if (got !== exp)
        begin
            failCount++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d, mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic mf;
        microframeStart = 1'h1;
        @(negedge clk);
        microframeStart = 1'h0;
        @(negedge clk);
    endtask : mf
    task automatic put(input logic [6:0] a, input logic [1:0] o,
        input logic [7:0] n, input logic ok);
        entWrValid = 1'h1;
        entAddr = a;
        entEndp = a[3:0];
        entOutcome = o;
        entLen = n;
        #1;
        chk("entWrReady", {7'h0, ok}, {7'h0, entWrReady});
        @(negedge clk);
        entWrValid = 1'h0;
        entAddr = ~a;
        // One idle edge keeps back-to-back entries apart
        @(negedge clk);
    endtask : put
    task automatic ask(input logic [6:0] a, input logic d,
        input logic [2:0] ek, input logic [7:0] en,
        input logic [4:0] es, input int et);
        logic [2:0] k;
        logic [7:0] n;
        logic [4:0] s;
        int t;
        i_host.split(a, a[3:0], d, 1'h1, 1'h0, k, n, s, t);
        chk("rspKind", {5'h0, ek}, {5'h0, k});
        chk("tries", 8'(et), 8'(t));
        if (ek != ANS_NYET)
        begin
            chk("rspLen", en, n);
            chk("slot", {3'h0, es}, {3'h0, s});
        end
    endtask : ask
    ////////////////////////////////////////////////////////////////////
    task automatic t_queue;
        logic [2:0] k;
        logic [7:0] n;
        logic [4:0] s;
        int t;
        put(7'h10, OUT_DATA, 8'h08, 1'h1);
        put(7'h11, OUT_NAK, 8'h09, 1'h1);
        put(7'h12, OUT_DATA, 8'h0a, 1'h1);
        put(7'h13, OUT_STALL, 8'h0b, 1'h1);
        put(7'h14, OUT_ERR, 8'h0c, 1'h1);
        ask(7'h10, 1'h1, ANS_NYET, 8'h0, 5'h0, 1);
        mf;
        i_host.split(7'h10, 4'h0, 1'h1, 1'h0, 1'h1, k, n, s, t);
        i_host.split(7'h10, 4'h0, 1'h1, 1'h0, 1'h1, k, n, s, t);
        chk("csReady", 8'h0, {7'h0, csReady});
        repeat (2)
        begin
            i_host.pop(k, n, s);
            chk("rspKind", 8'h0, {5'h0, k});
            chk("slot", 8'h0, {3'h0, s});
            @(negedge clk);
        end
        chk("rspValid", 8'h0, {7'h0, rspValid});
        ask(7'h11, 1'h0, ANS_NYET, 8'h0, 5'h0, 1);
        ask(7'h11, 1'h1, ANS_NAK, 8'h09, 5'h01, 1);
        ask(7'h13, 1'h1, ANS_STALL, 8'h0b, 5'h03, 1);
        ask(7'h12, 1'h1, ANS_NYET, 8'h0, 5'h0, 1);
        ask(7'h14, 1'h1, ANS_ERR, 8'h0c, 5'h04, 1);
    endtask : t_queue
    task automatic t_fill;
        mf;
        for (int i = 0; i < 16; i++)
            put(7'h40 + 7'(i), OUT_DATA, 8'h01, 1'h1);
        put(7'h50, OUT_DATA, 8'h01, 1'h0);
        mf;
        put(7'h30, OUT_NAK, 8'hb4, 1'h1);
        put(7'h31, OUT_NAK, 8'h09, 1'h0);
        put(7'h32, OUT_NAK, 8'h08, 1'h1);
        ask(7'h4c, 1'h1, ANS_DATA, 8'h01, 5'h0c, 2);
        ask(7'h4f, 1'h1, ANS_DATA, 8'h01, 5'h0f, 1);
        mf;
        mf;
        ask(7'h30, 1'h1, ANS_NYET, 8'h0, 5'h0, 1);
    endtask : t_fill
    task automatic t_retry;
        fsDone = 1'h1;
        fsErr = 1'h1;
        @(negedge clk);
        chk("fsRetryReq", 8'h1, {7'h0, fsRetryReq});
        fsIsInterrupt = 1'h1;
        @(negedge clk);
        chk("fsRetryReq", 8'h0, {7'h0, fsRetryReq});
        fsDone = 1'h0;
        fsErr = 1'h0;
    endtask : t_retry
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // Whole run needs a few hundred cycles; this 20000-cycle limit is far above that
    initial
    begin
        #400000;
        failCount++;
        close_out;
    end
    initial
    begin
        reset_n = 1'h0;
        microframeStart = 1'h0;
        entWrValid = 1'h0;
        entAddr = 7'h0;
        entEndp = 4'h0;
        entDirIn = 1'h1;
        entOutcome = 2'h0;
        entLen = 8'h0;
        fsDone = 1'h0;
        fsErr = 1'h0;
        fsIsInterrupt = 1'h0;
        repeat (20) @(negedge clk);
        reset_n = 1'h1;
        t_queue;
        t_fill;
        t_retry;
        chk("strikes", 8'h4, 8'(i_host.strikes));
        chk("halted", 8'h1, {7'h0, i_host.halted});
        close_out;
    end
endmodule : split_complete_response_matcher_tb_top
